// [wdt_params.svh]
// constants of the watchdog reset timer: offsets, fields, resets, timing
// assumes a 25 MHz core clock and an 8-bit special-function-register bus
//
// What this block does
// R1: while enabled, a timeout with no completed refresh raises system reset.
// R2: with the enable bit (bit 0) clear nothing runs and no reset is issued.
// R3: the timeout is measured by a 16-bit counter scaled by the prescale.
// R4: prescale bits 7..5 pick 16, 32, 64 ... 2048 ms for codes 000..111.
// R5: a refresh is the first refresh bit (3) set, then the second bit (2).
// R6: every watchdog timeout sets the status flag in bit 1.
// R7: the status flag clears only by writing 0 or by external reset.
// R8: setting the enable bit starts the watchdog with counters cleared.
// R9: a refresh restarts the count, clears both refresh bits, and the
//     second bit alone does nothing.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define WDT_CTRL_ADDR      8'hC0
`define WDT_CTRL_RESET     8'h00
`define WDT_EN_POS         0
`define WDT_STS_POS        1
`define WDT_R2_POS         2
`define WDT_R1_POS         3
`define WDT_PRE_LSB        5
`define WDT_PRE_MSB        7

// ****************************************************************
// timing
// ****************************************************************
`define WDT_CLK_PERIOD_NS  40
`define WDT_MS_IN_NS       1000000
`define WDT_BASE_TIMEOUT_MS 16
`define WDT_MAX_TIMEOUT_MS 2048
`define WDT_RST_CYCLES     8'h10

`endif

// [wdt_pkg.sv]
// types of the watchdog reset timer
// assumes wdt_params.svh is compiled with it
`default_nettype none

package wdt_pkg;

	// control register, laid out as the byte that software sees
	typedef struct packed {
		logic [2:0] pre;
		logic       unused;
		logic       r1;
		logic       r2;
		logic       sts;
		logic       en;
	} wdt_ctrl_t;

	// gray sequence: off, run, armed, reset
	typedef enum logic [1:0] {
		WDT_OFF   = 2'b00,
		WDT_RUN   = 2'b01,
		WDT_ARMED = 2'b11,
		WDT_RESET = 2'b10
	} wdt_fsm_t;

	typedef struct packed {
		wdt_ctrl_t  ctrl;
		wdt_fsm_t   fsm;
		logic [15:0] tick_cnt;
		logic [15:0] ms_cnt;
		logic [7:0]  rst_cnt;
		logic [7:0]  rdata;
	} wdt_state_t;

	// one special-function-register access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       bit_wr;
		logic [7:0] bit_addr;
		logic       bit_val;
	} wdt_sfr_req_t;

endpackage : wdt_pkg

`default_nettype wire

// [wdt_top.sv]
// watchdog reset timer with its single control register
// assumes the core drives SFR accesses synchronous to mclk_i, that
// arst_n_i is the power-on / external reset and that sys_rst_o is fed
// back into the system reset tree (but not into arst_n_i of this block)
`include "wdt_params.svh"
`default_nettype none

module wdt_top #(
	parameter int unsigned TICK_CYCLES = `WDT_MS_IN_NS / `WDT_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             arst_n_i,
	// special-function-register bus
	input  wire wdt_pkg::wdt_sfr_req_t sfr_i,
	output var  logic [7:0]       sfr_rdata_o,
	// system
	output var  logic             sys_rst_o,
	output var  logic             timeout_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [15:0] limit_ms(input logic [2:0] pre);
		limit_ms = 16'(`WDT_BASE_TIMEOUT_MS) << pre;
	endfunction

	function automatic logic [7:0] put_bit(input logic [7:0] val,
		input logic [2:0] idx, input logic b);
		logic [7:0] res;
		res      = val;
		res[idx] = b;
		put_bit  = res;
	endfunction

	wdt_pkg::wdt_state_t st;
	wdt_pkg::wdt_state_t next_st;
	logic                hit_byte;
	logic                hit_bit;
	logic                wr_any;
	logic [7:0]          wval;
	logic                tick;
	logic                timeout;
	logic                refresh;
	logic                en_rise;
	logic                clr_sts;
	logic [15:0]         lim;

	assign hit_byte = sfr_i.wr && (sfr_i.addr == `WDT_CTRL_ADDR);
	// bit addresses C0..C7 map onto the eight control bits
	assign hit_bit  = sfr_i.bit_wr &&
		(sfr_i.bit_addr[7:3] == 5'(`WDT_CTRL_ADDR >> 3));
	assign wr_any   = (hit_byte || hit_bit) && (st.fsm != wdt_pkg::WDT_RESET);
	assign wval     = hit_byte ? sfr_i.wdata :
		put_bit(st.ctrl, sfr_i.bit_addr[2:0], sfr_i.bit_val);

	assign lim     = limit_ms(st.ctrl.pre);                           // R4
	assign tick    = (st.tick_cnt == 16'(TICK_CYCLES - 1));
	assign refresh = wr_any && st.ctrl.r1 && wval[`WDT_R2_POS] &&     // R5
		(st.fsm == wdt_pkg::WDT_ARMED);
	// a late prescale change below the count times out at the next tick
	assign timeout = (st.fsm == wdt_pkg::WDT_RUN ||
		st.fsm == wdt_pkg::WDT_ARMED) && st.ctrl.en && tick &&
		(st.ms_cnt >= lim - 16'h0001) && !refresh;                // R1
	assign en_rise = wr_any && wval[`WDT_EN_POS] && !st.ctrl.en;
	assign clr_sts = wr_any && !wval[`WDT_STS_POS];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (sfr_i.rd && sfr_i.addr == `WDT_CTRL_ADDR) begin
			next_st.rdata = st.ctrl;
		end
		if (wr_any) begin
			next_st.ctrl.pre = wval[`WDT_PRE_MSB:`WDT_PRE_LSB];
			next_st.ctrl.en  = wval[`WDT_EN_POS];
			next_st.ctrl.r1  = wval[`WDT_R1_POS] | st.ctrl.r1;
			// second bit alone is dropped
			next_st.ctrl.r2  = 1'b0;                                  // R9
			if (clr_sts) begin
				next_st.ctrl.sts = 1'b0;                              // R7
			end
		end
		if (timeout) begin
			next_st.ctrl.sts = 1'b1;                                  // R6
		end
		case (st.fsm)
			wdt_pkg::WDT_OFF: begin
				next_st.tick_cnt = 16'h0000;
				next_st.ms_cnt   = 16'h0000;
				next_st.ctrl.r1  = 1'b0;
				if (en_rise) begin
					next_st.fsm     = wdt_pkg::WDT_RUN;               // R8
					next_st.ctrl.r1 = wval[`WDT_R1_POS];
					if (wval[`WDT_R1_POS]) begin
						next_st.fsm = wdt_pkg::WDT_ARMED;
					end
				end
			end
			wdt_pkg::WDT_RUN, wdt_pkg::WDT_ARMED: begin
				next_st.tick_cnt = tick ? 16'h0000 :
					st.tick_cnt + 16'h0001;
				if (tick) begin
					next_st.ms_cnt = st.ms_cnt + 16'h0001;            // R3
				end
				if (next_st.ctrl.r1) begin
					next_st.fsm = wdt_pkg::WDT_ARMED;
				end
				if (refresh) begin
					next_st.tick_cnt = 16'h0000;                      // R9
					next_st.ms_cnt   = 16'h0000;
					next_st.ctrl.r1  = 1'b0;
					next_st.fsm      = wdt_pkg::WDT_RUN;
				end
				if (wr_any && !wval[`WDT_EN_POS]) begin
					next_st.fsm     = wdt_pkg::WDT_OFF;               // R2
					next_st.ctrl.r1 = 1'b0;
				end
				if (timeout) begin
					next_st.fsm     = wdt_pkg::WDT_RESET;
					next_st.rst_cnt = `WDT_RST_CYCLES;
				end
			end
			wdt_pkg::WDT_RESET: begin
				// system reset returns control to defaults but keeps status
				next_st.ctrl     = `WDT_CTRL_RESET;
				next_st.ctrl.sts = 1'b1;                              // R7
				next_st.tick_cnt = 16'h0000;
				next_st.ms_cnt   = 16'h0000;
				next_st.rst_cnt  = st.rst_cnt - 8'h01;
				if (st.rst_cnt == 8'h01) begin
					next_st.fsm = wdt_pkg::WDT_OFF;
				end
			end
			default: begin
				next_st.fsm = wdt_pkg::WDT_OFF;
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st      <= '0;
			st.ctrl <= `WDT_CTRL_RESET;
			st.fsm  <= wdt_pkg::WDT_OFF;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata_o = st.rdata;
	assign sys_rst_o   = (st.fsm == wdt_pkg::WDT_RESET);                // R1
	assign timeout_o   = st.ctrl.sts;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_rst_cause: assert property ($rose(sys_rst_o) |-> // R1
		$past(st.ctrl.en) && $past(tick) &&
		$past(st.ms_cnt) >= $past(lim) - 16'h0001)
		else $error("system reset without an expired timeout");
	a_rst_len: assert property ($rose(sys_rst_o) |-> // R1
		sys_rst_o[*8] ##1 sys_rst_o[*8] ##1 !sys_rst_o)
		else $error("system reset pulse not sixteen cycles long");
	a_off_quiet: assert property (!st.ctrl.en && // R2
		st.fsm != wdt_pkg::WDT_RESET |=> !$rose(sys_rst_o))
		else $error("reset issued while disabled");
	a_cnt_bound: assert property (st.fsm != wdt_pkg::WDT_OFF |-> // R3
		st.ms_cnt <= 16'(`WDT_MAX_TIMEOUT_MS))
		else $error("timeout counter ran past the longest period");
	a_limit_sel: assert property (st.ctrl.pre == 3'h0 && timeout |-> // R4
		st.ms_cnt >= 16'h000F)
		else $error("shortest period expired early");
	a_refresh_ok: assert property (refresh |=> // R5
		st.ms_cnt == 16'h0000 && st.tick_cnt == 16'h0000 &&
		!st.ctrl.r1 && !st.ctrl.r2)
		else $error("refresh did not restart the count");
	a_sts_set: assert property (timeout |=> st.ctrl.sts) // R6
		else $error("timeout did not set the status flag");
	a_sts_keep: assert property ($fell(st.ctrl.sts) |-> // R7
		$past(clr_sts) && !$past(timeout))
		else $error("status flag cleared without a zero write");
	a_en_start: assert property (en_rise |=> // R8
		st.ms_cnt == 16'h0000 && st.fsm != wdt_pkg::WDT_OFF)
		else $error("enable did not start a clean count");
	a_lone_second: assert property (wr_any && !st.ctrl.r1 && // R9
		wval[`WDT_R2_POS] |=> !st.ctrl.r2 && $stable(st.ms_cnt) ||
		st.ms_cnt == $past(st.ms_cnt) + 16'h0001 || st.fsm !=
		wdt_pkg::WDT_RUN)
		else $error("second refresh bit alone had an effect");

	c_refresh: cover property (refresh);
	c_timeout: cover property ($rose(sys_rst_o));
	c_sts_clear: cover property ($fell(st.ctrl.sts));

endmodule // wdt_top

`default_nettype wire

// [wdt_core_model.sv]
// processor core model: byte, bit and read accesses on the register bus
// assumes mclk_i is the block clock; the bench calls its tasks
`default_nettype none

module wdt_core_model (
	// clock
	input  wire logic                  mclk_i,
	// register bus
	input  wire logic [7:0]            rdata_i,
	output var  wdt_pkg::wdt_sfr_req_t sfr_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// bus cycles
	// ****************************************************************
	initial sfr_o = '0;

	// released lines show the inverse so a stale value is never trusted
	task automatic acc(input wdt_pkg::wdt_sfr_req_t r);
		wdt_pkg::wdt_sfr_req_t idle;
		idle = ~r;
		idle.wr = 1'b0;
		idle.rd = 1'b0;
		idle.bit_wr = 1'b0;
		@(posedge mclk_i);
		sfr_o <= r;
		@(posedge mclk_i);
		sfr_o <= idle;
	endtask

	task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
		acc('{wr: 1'b1, addr: a, wdata: d, default: '0});
	endtask

	task automatic wr_byte(input logic [7:0] d);
		wr_at(8'hC0, d);
	endtask

	// ba is the full bit address; only C0..C7 reach the control bits
	task automatic bit_wr(input logic [7:0] ba, input logic v);
		acc('{bit_wr: 1'b1, bit_addr: ba, bit_val: v, default: '0});
	endtask

	// byte and bit strobes in one cycle: the byte write has to win
	task automatic wr_both(input logic [7:0] d, input logic [7:0] ba,
		input logic v);
		acc('{wr: 1'b1, addr: 8'hC0, wdata: d, bit_wr: 1'b1,
			bit_addr: ba, bit_val: v, default: '0});
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		acc('{rd: 1'b1, addr: a, default: '0});
		@(posedge mclk_i);
		d = rdata_i;
	endtask

	task automatic refresh();
		bit_wr(8'hC3, 1'b1);
		bit_wr(8'hC2, 1'b1);
	endtask
endmodule // wdt_core_model

`default_nettype wire

// [test_watchdog_reset_timer.sv]
// self-checking bench of the watchdog reset timer
// assumes wdt_pkg and wdt_core_model are compiled first
`default_nettype none

module test_watchdog_reset_timer;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// harness
	// ****************************************************************
	localparam int TICK = 4;
	logic                  mclk_i = 1'b0;
	logic                  arst_n_i = 1'b0;
	wdt_pkg::wdt_sfr_req_t sfr;
	logic [7:0]            rdata;
	logic                  sys_rst;
	logic                  tmo;
	logic [7:0]            d;
	int                    miscompares = 0;
	int                    n_tests = 0;
	int                    cyc = 0;

	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;

	wdt_top #(.TICK_CYCLES(TICK)) wdt_top_i (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
		.sys_rst_o(sys_rst), .timeout_o(tmo));
	wdt_core_model wdt_core_model_i (.mclk_i(mclk_i), .rdata_i(rdata),
		.sfr_o(sfr));

	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
		wdt_core_model_i.rd(a, d);
		chk("ctrl_read", {8'h00, exp}, {8'h00, d});
	endtask

	// n cycles after t0 the pulse must come; then 16 cycles, status kept
	task automatic wait_rst(int n, int t0);
		int h = 0;
		logic on_time;
		while (sys_rst !== 1'b1 && cyc - t0 < n + 8) @(posedge mclk_i);
		on_time = (cyc - t0 >= n - 3) && (cyc - t0 <= n + 3);
		chk("timeout_at", 16'h1, {15'h0, on_time});
		while (sys_rst === 1'b1 && h < 40) begin
			@(posedge mclk_i);
			h++;
		end
		chk("rst_len", 16'h0010, 16'(h));
		chk("status_out", 16'h1, {15'h0, tmo});
		rd_chk(8'hC0, 8'h02);
	endtask

	task automatic t_start();
		rd_chk(8'hC0, 8'h00);
		rd_chk(8'hC1, 8'h00);
		// writes that must leave the control register at 00: other addresses, and a bit write that loses to a byte write
		wdt_core_model_i.wr_at(8'hC1, 8'h01);
		rd_chk(8'hC0, 8'h00);
		wdt_core_model_i.bit_wr(8'hC8, 1'b1);
		rd_chk(8'hC0, 8'h00);
		wdt_core_model_i.wr_both(8'h00, 8'hC0, 1'b1);
		rd_chk(8'hC0, 8'h00);
		$display("test start done");
	endtask

	task automatic t_prescale();
		for (int p = 0; p < 8; p++) begin
			wdt_core_model_i.wr_byte({p[2:0], 5'h01});
			wait_rst((16 << p) * TICK, cyc);
			wdt_core_model_i.wr_byte(8'h00);
			rd_chk(8'hC0, 8'h00);
		end
		$display("test prescale done");
	endtask

	task automatic t_refresh();
		int t0;
		wdt_core_model_i.wr_byte(8'h01);
		t0 = cyc;
		repeat (30) @(posedge mclk_i);
		wdt_core_model_i.bit_wr(8'hC2, 1'b1);
		rd_chk(8'hC0, 8'h01);
		wait_rst(16 * TICK, t0);
		wdt_core_model_i.wr_byte(8'h01);
		repeat (40) @(posedge mclk_i);
		wdt_core_model_i.refresh();
		t0 = cyc;
		rd_chk(8'hC0, 8'h01);
		wait_rst(16 * TICK, t0);
		// a one to the status bit keeps it, a zero bit write clears it
		wdt_core_model_i.bit_wr(8'hC1, 1'b1);
		rd_chk(8'hC0, 8'h02);
		wdt_core_model_i.bit_wr(8'hC1, 1'b0);
		rd_chk(8'hC0, 8'h00);
		$display("test refresh done");
	endtask

	task automatic t_disable();
		logic seen = 1'b0;
		wdt_core_model_i.wr_byte(8'h01);
		repeat (40) @(posedge mclk_i);
		wdt_core_model_i.wr_byte(8'h00);
		repeat (100) begin
			@(posedge mclk_i);
			seen |= sys_rst;
		end
		chk("no_reset", 16'h0, {15'h0, seen});
		wdt_core_model_i.wr_byte(8'h01);
		wait_rst(16 * TICK, cyc);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		rd_chk(8'hC0, 8'h00);
		$display("test disable done");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// whole run needs about 17000 cycles
	initial begin
		repeat (30000) @(posedge mclk_i);
		miscompares++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_start();
		t_prescale();
		t_refresh();
		t_disable();
		close_out();
	end
endmodule // test_watchdog_reset_timer

`default_nettype wire
